/* rtl/icb_pkg.sv */
// Shared types and constants for the indirect call and breakpoint unit
package icb_pkg;

  // Data path width of the general registers and program counter
  localparam int          ICB_XLEN        = 32;
  // Width of a register specifier
  localparam int          ICB_RIDX        = 5;
  // Link register of the fixed-link call forms
  localparam logic [4:0]  ICB_LINK_DEF    = 5'h1F;
  // Link offset when the delay slot holds a 32-bit instruction
  localparam logic [31:0] ICB_LINK_LONG   = 32'h00000006;
  // Link offset when the delay slot holds a 16-bit instruction
  localparam logic [31:0] ICB_LINK_SHORT  = 32'h00000004;
  // Width of the ISA configuration field
  localparam int          ICB_ISACFG_W    = 2;
  // ISA configuration value that loads the whole target unchanged
  localparam logic [1:0]  ICB_ISACFG_FULL = 2'h1;
  // Alternate configuration value that loads the whole target unchanged
  localparam logic        ICB_ALTCFG_FULL = 1'h0;
  // Bit holding the ISA select in a target register
  localparam int          ICB_ISA_BIT     = 0;
  // Halfword alignment bit of a target address
  localparam int          ICB_HALF_BIT    = 1;

  // Decoded operation handed over by the decode stage
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BREAK,
    OP_CALL,
    OP_CALL_SS,
    OP_CALL_RT
  } icb_op_type;

  // Sequencing states of the unit
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SLOT,
    ST_FETCH
  } icb_state_type;

  // Issue request from decode
  typedef struct packed {
    logic                valid;
    icb_op_type          op;
    logic [ICB_XLEN-1:0] pc;
    logic [ICB_XLEN-1:0] tgtVal;
    logic [ICB_RIDX-1:0] linkSpec;
  } icb_issue_type;

  // Register file write port
  typedef struct packed {
    logic                en;
    logic [ICB_RIDX-1:0] idx;
    logic [ICB_XLEN-1:0] data;
  } icb_linkwr_type;

  // Program counter redirect
  typedef struct packed {
    logic                valid;
    logic [ICB_XLEN-1:0] pc;
    logic                isaLoad;
    logic                isaSel;
  } icb_redirect_type;

  // Whole state of the top module
  typedef struct packed {
    icb_state_type       st;
    logic [ICB_XLEN-1:0] tgt;
    logic                isaLoad;
    logic                isaSel;
    logic                errPend;
    logic                excBreak;
    logic                excAddr;
    icb_linkwr_type      linkWr;
    icb_redirect_type    redir;
  } icb_core_state_type;

endpackage : icb_pkg

/* rtl/icb_target_former.sv */
`timescale 1ns/1ps
`default_nettype none
// Forms the jump target, the ISA select and the deferred fault flag
module icb_target_former
  import icb_pkg::*;
#(
  parameter int XLEN = ICB_XLEN
) (
  input  wire icb_op_type              opKind,
  input  wire logic [XLEN-1:0]         regVal,
  input  wire logic                    fullIsaPresent,
  input  wire logic [ICB_ISACFG_W-1:0] isaConfigField,
  input  wire logic                    altIsaConfigBit,
  output logic      [XLEN-1:0]         targetPc,
  output logic                         isaLoad,
  output logic                         isaSel,
  output logic                         addrErr
);

  // Whole-value mode per call form
  logic wholeMode;

  // Target selection
  always_comb begin
    unique case (opKind)
      OP_CALL_RT: wholeMode = (altIsaConfigBit == ICB_ALTCFG_FULL);
      default:    wholeMode = (isaConfigField == ICB_ISACFG_FULL);
    endcase
    targetPc = regVal;
    isaLoad  = 1'b0;
    isaSel   = regVal[ICB_ISA_BIT];
    if (!wholeMode) begin
      // Bit 0 is dropped from the target, but addrErr still tests it
      targetPc[ICB_ISA_BIT] = 1'b0;
      isaLoad               = fullIsaPresent;
    end
  end

  // Faults are only reported later when the target is fetched
  always_comb begin
    if (fullIsaPresent) begin
      addrErr = !regVal[ICB_ISA_BIT] && regVal[ICB_HALF_BIT];
    end else begin
      addrErr = !regVal[ICB_ISA_BIT];
    end
  end

endmodule : icb_target_former
`default_nettype wire

/* rtl/icb_core.sv */
`timescale 1ns/1ps
`default_nettype none
module icb_core
  import icb_pkg::*;
#(
  parameter int XLEN = ICB_XLEN
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire icb_issue_type           issue,
  output logic                         issueReady,
  input  wire logic                    slotDone,
  input  wire logic                    slotFlush,
  input  wire logic                    targetFetched,
  input  wire logic                    fullIsaPresent,
  input  wire logic [ICB_ISACFG_W-1:0] isaConfigField,
  input  wire logic                    altIsaConfigBit,
  output icb_linkwr_type               linkWr,
  output icb_redirect_type             redirect,
  output logic                         excBreak,
  output logic                         excAddr,
  output icb_state_type                unitState
);

  // Registered state and its next value
  icb_core_state_type state;
  icb_core_state_type next_state;

  // Combinational outputs of the target former
  logic [XLEN-1:0] formPc;
  logic            formIsaLoad;
  logic            formIsaSel;
  logic            formErr;

  // Decoded issue qualifiers
  logic            take;
  logic            isCall;
  logic [XLEN-1:0] linkOfs;

  // Target former works on the value read in the jump stage
  icb_target_former #(
    .XLEN (XLEN)
  ) u_former (
    .opKind          (issue.op),
    .regVal          (issue.tgtVal),
    .fullIsaPresent  (fullIsaPresent),
    .isaConfigField  (isaConfigField),
    .altIsaConfigBit (altIsaConfigBit),
    .targetPc        (formPc),
    .isaLoad         (formIsaLoad),
    .isaSel          (formIsaSel),
    .addrErr         (formErr)
  );

  // New work is accepted only when no call is in flight
  assign issueReady = (state.st == ST_IDLE);
  assign take       = issue.valid && issueReady;
  assign isCall     = (issue.op == OP_CALL) || (issue.op == OP_CALL_SS) || (issue.op == OP_CALL_RT);

  // Link offset depends on the size of the delay slot
  always_comb begin
    if (issue.op == OP_CALL_SS) begin
      linkOfs = XLEN'(ICB_LINK_SHORT);
    end else begin
      linkOfs = XLEN'(ICB_LINK_LONG);
    end
  end

  // Next state
  always_comb begin
    next_state                = state;
    // Pulses default low
    next_state.excBreak       = 1'b0;
    next_state.excAddr        = 1'b0;
    next_state.linkWr.en      = 1'b0;
    next_state.redir.valid    = 1'b0;
    unique case (state.st)
      ST_IDLE: begin
        if (take && (issue.op == OP_BREAK)) begin
          // No condition and no code field is passed on
          next_state.excBreak = 1'b1;
        end else if (take && isCall) begin
          // Capture target and write link before the slot runs
          next_state.tgt         = ICB_XLEN'(formPc);
          next_state.isaLoad     = formIsaLoad;
          next_state.isaSel      = formIsaSel;
          next_state.errPend     = formErr;
          next_state.linkWr.en   = 1'b1;
          next_state.linkWr.data = ICB_XLEN'(issue.pc + linkOfs);
          if (issue.op == OP_CALL_RT) begin
            next_state.linkWr.idx = issue.linkSpec;
          end else begin
            next_state.linkWr.idx = ICB_LINK_DEF;
          end
          next_state.st = ST_SLOT;
        end
      end
      ST_SLOT: begin
        if (slotFlush) begin
          // Exception in the slot: the call is re-executed later
          next_state.st = ST_IDLE;
        end else if (slotDone) begin
          // Transfer only after the delay slot completes
          next_state.redir.valid   = 1'b1;
          next_state.redir.pc      = state.tgt;
          next_state.redir.isaLoad = state.isaLoad;
          next_state.redir.isaSel  = state.isaSel;
          next_state.st            = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (slotFlush) begin
          // Redirect was cancelled before the target arrived
          next_state.st = ST_IDLE;
        end else if (targetFetched) begin
          // Fault raised only on the target fetch
          next_state.excAddr = state.errPend;
          next_state.st      = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign linkWr    = state.linkWr;
  assign redirect  = state.redir;
  assign excBreak  = state.excBreak;
  assign excAddr   = state.excAddr;
  assign unitState = state.st;

  // Breakpoint shows one cycle after it is taken
  AST_BREAK_NOW: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_BREAK) |=> (excBreak && !linkWr.en && !redirect.valid))
    else $error("breakpoint not raised at once");

  // A breakpoint never comes from anything but a breakpoint issue
  AST_BREAK_CAUSE: assert property (
    @(posedge clk) disable iff (!resetn)
    excBreak |-> ($past(take) && $past(issue.op) == OP_BREAK))
    else $error("spurious breakpoint");

  // Long-slot calls link six past the call
  AST_LINK_LONG: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL) |=>
      (linkWr.en && linkWr.idx == ICB_LINK_DEF && linkWr.data == $past(issue.pc) + ICB_LINK_LONG))
    else $error("wrong link for long-slot call");

  // Selectable link register with long slot
  AST_LINK_RT: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL_RT) |=>
      (linkWr.en && linkWr.idx == $past(issue.linkSpec) && linkWr.data == $past(issue.pc) + ICB_LINK_LONG))
    else $error("wrong link for selectable call");

  // Short-slot fixed call links four past the call
  AST_LINK_SHORT: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL_SS) |=>
      (linkWr.en && linkWr.idx == ICB_LINK_DEF && linkWr.data == $past(issue.pc) + ICB_LINK_SHORT))
    else $error("wrong link for short-slot call");

  // Redirect waits for the delay slot
  AST_SLOT_FIRST: assert property (
    @(posedge clk) disable iff (!resetn)
    redirect.valid |-> ($past(state.st) == ST_SLOT && $past(slotDone) && !$past(slotFlush)))
    else $error("redirect before delay slot");

  // Link is written before the slot can finish
  AST_LINK_BEFORE: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && isCall) |=> (linkWr.en && state.st == ST_SLOT) ##1 !linkWr.en)
    else $error("link not written in jump stage");

  // Captured target is not moved by later register values
  AST_TGT_HELD: assert property (
    @(posedge clk) disable iff (!resetn)
    (state.st == ST_SLOT && $past(state.st) == ST_SLOT) |-> $stable(state.tgt))
    else $error("target changed during delay slot");

  // Cleared bit zero outside whole-value mode
  AST_BIT0_CLEAR: assert property (
    @(posedge clk) disable iff (!resetn)
    (redirect.valid && redirect.isaLoad) |-> !redirect.pc[ICB_ISA_BIT])
    else $error("target bit zero not cleared");

  // Whole-value mode under the ISA config field
  AST_WHOLE_CFG: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL && isaConfigField == ICB_ISACFG_FULL) |=> state.tgt == $past(issue.tgtVal))
    else $error("whole value not kept");

  // Whole-value mode under the alternate config bit
  AST_WHOLE_ALT: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL_RT && altIsaConfigBit == ICB_ALTCFG_FULL) |=> state.tgt == $past(issue.tgtVal))
    else $error("whole value not kept for selectable call");

  // ISA select follows bit zero of the register
  AST_ISA_SEL: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && isCall && fullIsaPresent && isaConfigField != ICB_ISACFG_FULL && issue.op != OP_CALL_RT) |=>
      (state.isaLoad && state.isaSel == $past(issue.tgtVal[ICB_ISA_BIT])))
    else $error("ISA select not loaded");

  // Address fault only on a target fetch
  AST_FAULT_LATE: assert property (
    @(posedge clk) disable iff (!resetn)
    excAddr |-> ($past(state.st) == ST_FETCH && $past(targetFetched) && $past(state.errPend)))
    else $error("address fault not deferred");

  // Misaligned full-ISA target faults at fetch
  AST_FAULT_HALF: assert property (
    @(posedge clk) disable iff (!resetn)
    (state.st == ST_FETCH && targetFetched && !slotFlush && state.errPend) |=> excAddr)
    else $error("missed address fault");

  // A breakpoint carries nothing but the exception itself
  AST_BREAK_ALONE: assert property (
    @(posedge clk) disable iff (!resetn)
    excBreak |-> (!linkWr.en && !redirect.valid && !excAddr && unitState == ST_IDLE))
    else $error("breakpoint carried other work");

  // The link is written only for a call taken one cycle earlier
  AST_LINK_CAUSE: assert property (
    @(posedge clk) disable iff (!resetn)
    linkWr.en |-> ($past(take) && $past(isCall)))
    else $error("spurious link write");

  // Whole-value mode for the short-slot fixed call
  AST_WHOLE_SS: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL_SS && isaConfigField == ICB_ISACFG_FULL) |=>
      (state.tgt == $past(issue.tgtVal)))
    else $error("whole value not kept for short-slot call");

  // Outside whole-value mode bit zero is dropped and the rest kept
  AST_CLEAR_CFG: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && (issue.op == OP_CALL || issue.op == OP_CALL_SS) && isaConfigField != ICB_ISACFG_FULL) |=>
      (state.tgt == {$past(issue.tgtVal[ICB_XLEN-1:1]), 1'b0}))
    else $error("bit zero kept outside whole-value mode");

  // Selectable call outside whole-value mode clears bit zero and keeps it as select
  AST_CLEAR_ALT: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && issue.op == OP_CALL_RT && altIsaConfigBit != ICB_ALTCFG_FULL) |=>
      (state.tgt == {$past(issue.tgtVal[ICB_XLEN-1:1]), 1'b0} &&
       state.isaSel == $past(issue.tgtVal[ICB_ISA_BIT])))
    else $error("selectable call target not formed");

  // Without the full-width set the ISA select is never loaded
  AST_ISA_NONE: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && isCall && !fullIsaPresent) |=> !state.isaLoad)
    else $error("ISA select loaded without full-width set");

  // Full-width set: a pending fault is bit zero clear with bit one set
  AST_ERR_FULL: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && isCall && fullIsaPresent) |=>
      (state.errPend == (!$past(issue.tgtVal[ICB_ISA_BIT]) && $past(issue.tgtVal[ICB_HALF_BIT]))))
    else $error("wrong pending fault with full-width set");

  // Without the full-width set a clear bit zero is a pending fault
  AST_ERR_NOFULL: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && isCall && !fullIsaPresent) |=> (state.errPend == !$past(issue.tgtVal[ICB_ISA_BIT])))
    else $error("wrong pending fault without full-width set");

  // The call itself and a cancelled fetch raise no fault
  AST_NO_FAULT: assert property (
    @(posedge clk) disable iff (!resetn)
    ((take && isCall) || (state.st == ST_FETCH && slotFlush)) |=> !excAddr)
    else $error("address fault outside target fetch");

  // No redirect while the delay slot is still running
  AST_SLOT_WAIT: assert property (
    @(posedge clk) disable iff (!resetn)
    (state.st == ST_SLOT && !slotDone && !slotFlush) |=> (!redirect.valid && unitState == ST_SLOT))
    else $error("left delay slot early");

  // Redirect carries the target captured in the jump stage
  AST_REDIR_TGT: assert property (
    @(posedge clk) disable iff (!resetn)
    redirect.valid |-> (redirect.pc == state.tgt && redirect.isaLoad == state.isaLoad))
    else $error("redirect lost captured target");

endmodule : icb_core
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import icb_pkg::*;
  logic             clk;             // Core clock
  logic             resetn;          // Synchronous reset, active low
  icb_issue_type    issue;           // Request from decode
  logic             issueReady;      // Unit idle
  logic             slotDone;        // Delay slot finished
  logic             slotFlush;       // Exception cancel
  logic             targetFetched;   // Target fetched
  logic             fullIsaPresent;  // Full-width set present
  logic [1:0]       isaConfigField;  // ISA configuration
  logic             altIsaConfigBit; // Alternate configuration
  icb_linkwr_type   linkWr;          // Link write
  icb_redirect_type redirect;        // PC redirect
  logic             excBreak;        // Breakpoint pulse
  logic             excAddr;         // Address error pulse
  icb_state_type    unitState;       // Sequencer state
  logic [39:0]      expq[$];         // Expected events, oldest first
  logic [31:0]      rnd;             // Random state
  int               miscompares;     // Mismatch count
  int               n_compared;      // Comparison count

  icb_core uut (
    .clk            (clk),
    .resetn         (resetn),
    .issue          (issue),
    .issueReady     (issueReady),
    .slotDone       (slotDone),
    .slotFlush      (slotFlush),
    .targetFetched  (targetFetched),
    .fullIsaPresent (fullIsaPresent),
    .isaConfigField (isaConfigField),
    .altIsaConfigBit(altIsaConfigBit),
    .linkWr         (linkWr),
    .redirect       (redirect),
    .excBreak       (excBreak),
    .excAddr        (excAddr),
    .unitState      (unitState)
  );

  // Clock generator, 5 ns period
  always #2.5 clk = ~clk;

  // Galois-free shift register step for stimulus
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // Compare seen against expected and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // Take the oldest note; an unexpected event never matches
  task automatic pop(input logic [39:0] seen);
    logic [39:0] e;
    e = (expq.size() > 0) ? expq.pop_front() : ~seen;
    chk(seen, e);
  endtask : pop

  // Verdict and end of run
  task automatic results;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Output watcher, settled values at the falling edge
  always @(negedge clk) begin
    if (resetn === 1'b1) begin
      if (linkWr.en !== 1'b0) pop({3'h0, linkWr.idx, linkWr.data});
      if (redirect.valid !== 1'b0) pop({6'h10, redirect.pc, redirect.isaLoad,
                                        redirect.isaLoad & redirect.isaSel});
      if (excBreak !== 1'b0) pop(40'h80_0000_0000);
      if (excAddr !== 1'b0) pop(40'hC0_0000_0000);
    end
  end

  // One call from issue to target fetch; fl 1 flushes the slot, 2 the fetch
  task automatic call_op(input icb_op_type op, input logic [31:0] v, input logic [1:0] fl);
    logic        whole;
    logic        err;
    logic [31:0] p;
    rnd = nxt(rnd);
    p = {rnd[31:1], 1'b0};
    whole = (op == OP_CALL_RT) ? (altIsaConfigBit == ICB_ALTCFG_FULL) : (isaConfigField == ICB_ISACFG_FULL);
    err = fullIsaPresent ? (!v[0] && v[1]) : !v[0];
    // Target value is read before the link lands, so link and target never alias
    issue = '{valid: 1'b1, op: op, pc: p, tgtVal: v, linkSpec: rnd[8:4]};
    expq.push_back({3'h0, (op == OP_CALL_RT) ? rnd[8:4] : ICB_LINK_DEF,
                    p + ((op == OP_CALL_SS) ? ICB_LINK_SHORT : ICB_LINK_LONG)});
    @(negedge clk);
    // Busy: a breakpoint now is refused, and the target register changes
    issue = '{valid: 1'b1, op: OP_BREAK, pc: ~p, tgtVal: ~v, linkSpec: 5'h00};
    chk({38'h0, unitState}, {38'h0, ST_SLOT});
    @(negedge clk);
    issue.valid = 1'b0;
    repeat (rnd[1:0]) @(negedge clk);
    if (fl == 2'h1) begin
      slotFlush = 1'b1;
    end else begin
      // Slot holds a plain instruction of the size the call form wants
      slotDone = 1'b1;
      expq.push_back({6'h10, whole ? v : {v[31:1], 1'b0}, !whole & fullIsaPresent,
                      !whole & fullIsaPresent & v[0]});
    end
    @(negedge clk);
    slotDone = 1'b0;
    slotFlush = 1'b0;
    if (fl != 2'h1) begin
      chk({38'h0, unitState}, {38'h0, ST_FETCH});
      repeat (rnd[3:2]) @(negedge clk);
      // Fault shows only once the target is fetched, never on flush
      if (fl == 2'h2) slotFlush = 1'b1;
      else targetFetched = 1'b1;
      if (err && fl == 2'h0) expq.push_back(40'hC0_0000_0000);
      @(negedge clk);
      targetFetched = 1'b0;
      slotFlush = 1'b0;
    end
    @(negedge clk);
    chk({39'h0, issueReady}, 40'h1);
  endtask : call_op

  // Main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    issue = '0;
    slotDone = 1'b0;
    slotFlush = 1'b0;
    targetFetched = 1'b0;
    fullIsaPresent = 1'b0;
    isaConfigField = 2'h0;
    altIsaConfigBit = 1'b0;
    miscompares = 0;
    n_compared = 0;
    rnd = 32'h00007EAE;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk({39'h0, issueReady}, 40'h1);
    // Back-to-back breakpoints, then an empty operation
    issue = '{valid: 1'b1, op: OP_BREAK, pc: 32'h00000100, tgtVal: 32'h0, linkSpec: 5'h00};
    expq.push_back(40'h80_0000_0000);
    @(negedge clk);
    expq.push_back(40'h80_0000_0000);
    @(negedge clk);
    issue.op = OP_NONE;
    @(negedge clk);
    issue.valid = 1'b0;
    @(negedge clk);
    // All call forms over random configurations and target bit patterns
    for (int i = 0; i < 60; i++) begin
      rnd = nxt(rnd);
      fullIsaPresent = rnd[0];
      isaConfigField = rnd[2:1];
      altIsaConfigBit = rnd[3];
      // Targets of either alignment; misaligned ones must fault only at fetch
      call_op((i % 3 == 0) ? OP_CALL : (i % 3 == 1) ? OP_CALL_SS : OP_CALL_RT,
              {rnd[31:2], i[2:1]}, (i % 8 == 5) ? 2'h1 : (i % 8 == 6) ? 2'h2 : 2'h0);
    end
    repeat (3) @(negedge clk);
    chk(40'(expq.size()), 40'h0);
    results();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule : tb
`default_nettype wire
